// file: core/ppm_map.svh
/*
  Constants of the pixel port multiplexer: group sizes, pipeline latency,
  palette geometry, host address layout and buffer depth.
  Assumes inclusion by bare name from any file that needs these figures.
*/
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH

`define PPM_PORTS        5
`define PPM_PIX_W        8
`define PPM_OVL_W        2
`define PPM_GROUP_MIN    3'h4
`define PPM_GROUP_MAX    3'h5
`define PPM_LATENCY      9
`define PPM_STAMP_W      4
`define PPM_PAL_ENTRIES  256
`define PPM_OVL_ENTRIES  4
`define PPM_HOST_ADDR_W  9
`define PPM_HOST_OVL_BIT 8
`define PPM_COL_W        24
`define PPM_BUF_DEPTH    2
`define PPM_SYNC_W       55

`endif

// file: core/ppm_pkg.sv
/*
  Types shared by the pixel port multiplexer modules.
  Assumes ppm_map.svh is on the include path.
*/
`include "ppm_map.svh"

package ppm_pkg;

  typedef enum logic [0:0] {
    PPM_SH_IDLE = 1'b0,
    PPM_SH_RUN  = 1'b1
  } ppm_sh_t;

  typedef struct packed {
    logic                        vld;
    logic                        first;
    logic [`PPM_STAMP_W-1:0]     stamp;
    logic [`PPM_PIX_W-1:0]       idx;
    logic [`PPM_OVL_W-1:0]       ovl;
    logic [`PPM_COL_W-1:0]       col;
    logic                        sync_n;
    logic                        blank_n;
  } ppm_pipe_t;

endpackage : ppm_pkg

// file: core/ppm_sync.sv
/*
  Two flip-flop synchroniser of W bits, also used to release reset.
  Assumes d is stable enough that each bit settles within two clocks.
*/
`timescale 1ns/1ns
`default_nettype none

module ppm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Sampling clock
  input  wire logic         rstn,  // Asynchronous reset, active low
  input  wire logic [W-1:0] d,     // Asynchronous input
  output logic      [W-1:0] q      // Synchronised copy
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppm_sync_st_t;

  ppm_sync_st_t s_r;
  ppm_sync_st_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;

endmodule : ppm_sync

`default_nettype wire

// file: core/ppm_fifo.sv
/*
  Shift-style buffer of DEPTH entries; the head entry is the output register.
  Assumes the writer honours in_ready; all outputs come from flip-flops.
*/
`timescale 1ns/1ns
`default_nettype none

module ppm_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,        // System clock
  input  wire logic         rstn,       // Synchronised reset, active low
  input  wire logic         in_valid,   // Write request
  output logic              in_ready,   // Room for one more word
  input  wire logic [W-1:0] in_data,    // Write word
  output logic              out_valid,  // Head word present
  input  wire logic         out_ready,  // Reader takes head word
  output logic      [W-1:0] out_data    // Head word
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [DEPTH-1:0]        vld;
    logic                    rdy;
  } ppm_fifo_st_t;

  ppm_fifo_st_t s_r;
  ppm_fifo_st_t s_nxt;

  always_comb begin
    logic placed;
    s_nxt  = s_r;
    placed = 1'b0;
    if (s_r.vld[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_nxt.ent[i] = s_r.ent[i+1];
        s_nxt.vld[i] = s_r.vld[i+1];
      end
      s_nxt.vld[DEPTH-1] = 1'b0;
    end
    // Ready is registered, so a write is only taken against the advertised room
    if (in_valid && s_r.rdy) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!s_nxt.vld[i] && !placed) begin
          s_nxt.ent[i] = in_data;
          s_nxt.vld[i] = 1'b1;
          placed       = 1'b1;
        end
      end
    end
    s_nxt.rdy = !s_nxt.vld[DEPTH-1];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r     <= '0;
      s_r.rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready  = s_r.rdy;
  assign out_valid = s_r.vld[0];
  assign out_data  = s_r.ent[0];

  AST_BUF_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head changed while stalled");

endmodule : ppm_fifo

`default_nettype wire

// file: core/ppm_pixel_port_mux.sv
/*
  Pixel input front end: five parallel pixel ports latched per load strobe,
  resynchronised to the pixel clock, serialised, looked up in a dual-ported
  palette and delivered with overlay, sync and blank after a fixed latency.
  Assumes pix_clk and the load strobe arrive asynchronously and are sampled
  by clk at a much higher rate; the host palette port is on clk.
*/
// Summary of operation
// - Each strobe rise latches four or five pixels
// - Five ports, multiplexed into one pixel stream
// - Internal strobe aligned to internal pixel clock
// - Internal strobe lags external by at most one pixel
// - External strobe rise loads master register
// - Internal strobe moves master into slave register
// - Later stages advance on pixel clock only
// - Overlay, sync, blank follow pixel path aligned
// - Input to converter latency exactly nine pixels
// - Latency fixed without any clock start sequence
// - Each channel driven by 8-bit code
// - Palette dual-ported: lookup during host writes
// - Up to 256 palette entries shown together
// - Host writes accepted every cycle, no waits
`timescale 1ns/1ns
`default_nettype none
`include "ppm_map.svh"

module ppm_pixel_port_mux #(
  parameter int BUF_DEPTH = `PPM_BUF_DEPTH
) (
  input  wire logic                                   clk,           // System clock, 250 MHz
  input  wire logic                                   rstn,          // Async reset, active low
  input  wire logic                                   pix_clk,       // External pixel clock
  input  wire logic                                   pixel_group_load_strobe, // Group strobe
  input  wire logic [`PPM_PORTS-1:0][`PPM_PIX_W-1:0] pix_port,      // Pixel select ports
  input  wire logic [`PPM_PORTS-1:0][`PPM_OVL_W-1:0] ovl_port,      // Overlay select ports
  input  wire logic                                   sync_n_in,     // Sync, active low
  input  wire logic                                   blank_n_in,    // Blank, active low
  input  wire logic                                   group_of_five, // Five pixels per strobe
  input  wire logic                                   host_wr,       // Palette write strobe
  input  wire logic [`PPM_HOST_ADDR_W-1:0]            host_addr,     // Palette write address
  input  wire logic [`PPM_COL_W-1:0]                  host_data,     // Red, green, blue
  output logic                                        out_valid,     // Converter word present
  input  wire logic                                   out_ready,     // Receiver takes word
  output logic      [`PPM_PIX_W-1:0]                  red,           // Red code
  output logic      [`PPM_PIX_W-1:0]                  green,         // Green code
  output logic      [`PPM_PIX_W-1:0]                  blue,          // Blue code
  output logic                                        sync_n,        // Sync out, active low
  output logic                                        blank_n,       // Blank out, active low
  output logic                                        buf_ready,     // Buffer has room
  output logic                                        overflow       // Word lost, sticky
);

  localparam int DLY_N = `PPM_LATENCY - 4;
  localparam int OUT_W = `PPM_COL_W + 2;

  typedef struct packed {
    logic                                  pclk_q;
    logic                                  ld_q;
    logic [`PPM_STAMP_W-1:0]               tick_cnt;
    logic [`PPM_PORTS-1:0][`PPM_PIX_W-1:0] mst_pix;
    logic [`PPM_PORTS-1:0][`PPM_OVL_W-1:0] mst_ovl;
    logic                                  mst_sync_n;
    logic                                  mst_blank_n;
    logic [2:0]                            mst_cnt;
    logic [`PPM_STAMP_W-1:0]               mst_stamp;
    logic                                  ld_pend;
    logic [`PPM_PORTS-1:0][`PPM_PIX_W-1:0] slv_pix;
    logic [`PPM_PORTS-1:0][`PPM_OVL_W-1:0] slv_ovl;
    logic                                  slv_sync_n;
    logic                                  slv_blank_n;
    logic [2:0]                            slv_cnt;
    logic [`PPM_STAMP_W-1:0]               slv_stamp;
    ppm_pkg::ppm_sh_t                      sh;
    logic [2:0]                            idx;
    ppm_pkg::ppm_pipe_t                    mux;
    ppm_pkg::ppm_pipe_t                    look;
    ppm_pkg::ppm_pipe_t [DLY_N-1:0]        dly;
    ppm_pkg::ppm_pipe_t                    conv;
    logic                                  push;
    logic                                  ovf;
  } ppm_top_st_t;

  ppm_top_st_t s_r;
  ppm_top_st_t s_nxt;

  logic                                  rst_sync_n;
  logic [`PPM_SYNC_W-1:0]                sy;
  logic                                  sy_pclk;
  logic                                  sy_ld;
  logic                                  sy_five;
  logic                                  sy_sync_n;
  logic                                  sy_blank_n;
  logic [`PPM_PORTS-1:0][`PPM_OVL_W-1:0] sy_ovl;
  logic [`PPM_PORTS-1:0][`PPM_PIX_W-1:0] sy_pix;
  logic                                  pix_tick;
  logic                                  ld_rise;
  logic                                  int_ld;
  logic                                  fifo_rdy;
  logic [OUT_W-1:0]                      fifo_q;

  // Palette memories: written by the host, read by the pixel path
  logic [`PPM_COL_W-1:0] pal_mem [0:`PPM_PAL_ENTRIES-1];
  logic [`PPM_COL_W-1:0] ovl_mem [0:`PPM_OVL_ENTRIES-1];

  ppm_sync #(
    .W (1)
  ) u_rst_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (1'b1),
    .q    (rst_sync_n)
  );

  // Strobe, clock and data share one synchroniser so their sample times match
  ppm_sync #(
    .W (`PPM_SYNC_W)
  ) u_in_sync (
    .clk  (clk),
    .rstn (rst_sync_n),
    .d    ({pix_clk, pixel_group_load_strobe, group_of_five, sync_n_in, blank_n_in,
            ovl_port, pix_port}),
    .q    (sy)
  );

  assign {sy_pclk, sy_ld, sy_five, sy_sync_n, sy_blank_n, sy_ovl, sy_pix} = sy;

  // Internal pixel clock and internal strobe are both ticks of clk, aligned by construction
  assign pix_tick = sy_pclk && !s_r.pclk_q;
  assign ld_rise  = sy_ld && !s_r.ld_q;
  assign int_ld   = pix_tick && s_r.ld_pend;

  // Host writes land in one cycle, so any host rate up to clk needs no wait
  always_ff @(posedge clk) begin
    if (host_wr) begin
      if (host_addr[`PPM_HOST_OVL_BIT]) begin
        ovl_mem[host_addr[1:0]] <= host_data;
      end else begin
        pal_mem[host_addr[`PPM_PIX_W-1:0]] <= host_data;
      end
    end
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.pclk_q = sy_pclk;
    s_nxt.ld_q   = sy_ld;
    s_nxt.push   = 1'b0;
    if (pix_tick) begin
      s_nxt.tick_cnt = s_r.tick_cnt + 4'h1;
    end
    if (int_ld) begin
      s_nxt.ld_pend = 1'b0;
    end
    // Master captures on the external strobe; no start-up sequence is involved
    if (ld_rise) begin
      s_nxt.mst_pix     = sy_pix;
      s_nxt.mst_ovl     = sy_ovl;
      s_nxt.mst_sync_n  = sy_sync_n;
      s_nxt.mst_blank_n = sy_blank_n;
      s_nxt.mst_cnt     = sy_five ? `PPM_GROUP_MAX : `PPM_GROUP_MIN;
      s_nxt.mst_stamp   = s_nxt.tick_cnt;
      s_nxt.ld_pend     = 1'b1;
    end
    if (pix_tick) begin
      s_nxt.mux = '0;
      if (s_r.sh == ppm_pkg::PPM_SH_RUN) begin
        s_nxt.mux.vld     = 1'b1;
        s_nxt.mux.first   = (s_r.idx == 3'h0);
        s_nxt.mux.stamp   = s_r.slv_stamp;
        s_nxt.mux.idx     = s_r.slv_pix[s_r.idx];
        s_nxt.mux.ovl     = s_r.slv_ovl[s_r.idx];
        s_nxt.mux.sync_n  = s_r.slv_sync_n;
        s_nxt.mux.blank_n = s_r.slv_blank_n;
        s_nxt.idx         = s_r.idx + 3'h1;
        if (s_r.idx == s_r.slv_cnt - 3'h1) begin
          s_nxt.sh = ppm_pkg::PPM_SH_IDLE;
        end
      end
      // A fresh group cuts short any pixels left from the previous one
      if (int_ld) begin
        s_nxt.slv_pix     = s_r.mst_pix;
        s_nxt.slv_ovl     = s_r.mst_ovl;
        s_nxt.slv_sync_n  = s_r.mst_sync_n;
        s_nxt.slv_blank_n = s_r.mst_blank_n;
        s_nxt.slv_cnt     = s_r.mst_cnt;
        s_nxt.slv_stamp   = s_r.mst_stamp;
        s_nxt.idx         = 3'h0;
        s_nxt.sh          = ppm_pkg::PPM_SH_RUN;
      end
      s_nxt.look = s_r.mux;
      if (s_r.mux.ovl != 2'h0) begin
        s_nxt.look.col = ovl_mem[s_r.mux.ovl];
      end else begin
        s_nxt.look.col = pal_mem[s_r.mux.idx];
      end
      s_nxt.dly  = {s_r.dly[DLY_N-2:0], s_r.look};
      s_nxt.conv = s_r.dly[DLY_N-1];
      s_nxt.push = s_r.dly[DLY_N-1].vld;
    end
    // Video cannot stall, so a full buffer drops the word and records it
    if (s_r.push && !fifo_rdy) begin
      s_nxt.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ppm_fifo #(
    .W     (OUT_W),
    .DEPTH (BUF_DEPTH)
  ) u_out_buf (
    .clk       (clk),
    .rstn      (rst_sync_n),
    .in_valid  (s_r.push),
    .in_ready  (fifo_rdy),
    .in_data   ({s_r.conv.col, s_r.conv.sync_n, s_r.conv.blank_n}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_q)
  );

  // Three 8-bit codes per palette entry
  assign red       = fifo_q[OUT_W-1 -: `PPM_PIX_W];
  assign green     = fifo_q[OUT_W-1-`PPM_PIX_W -: `PPM_PIX_W];
  assign blue      = fifo_q[OUT_W-1-2*`PPM_PIX_W -: `PPM_PIX_W];
  assign sync_n    = fifo_q[1];
  assign blank_n   = fifo_q[0];
  assign buf_ready = fifo_rdy;
  assign overflow  = s_r.ovf;

  AST_MASTER_CAPTURE: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ld_rise |=> s_r.mst_pix == $past(sy_pix) && s_r.mst_ovl == $past(sy_ovl)
                && s_r.mst_sync_n == $past(sy_sync_n) && s_r.ld_pend)
    else $error("master register missed the strobe");

  AST_SLAVE_ON_INT: assert property (@(posedge clk) disable iff (!rst_sync_n)
    int_ld |=> s_r.slv_pix == $past(s_r.mst_pix) && s_r.idx == 3'h0
               && s_r.sh == ppm_pkg::PPM_SH_RUN)
    else $error("slave register not loaded on internal strobe");

  AST_INT_LAG: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_r.ld_pend && pix_tick && !ld_rise |=> !s_r.ld_pend)
    else $error("internal strobe lags by a pixel or more");

  AST_STAGES_ON_TICK: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !pix_tick |=> $stable(s_r.dly) && $stable(s_r.look) && $stable(s_r.conv) && !s_r.push)
    else $error("pipeline moved without a pixel clock");

  AST_ORDER: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pix_tick && s_r.sh == ppm_pkg::PPM_SH_RUN && !int_ld
      |=> s_r.mux.vld && s_r.idx == $past(s_r.idx) + 3'h1
          && s_r.mux.idx == $past(s_r.slv_pix[s_r.idx]))
    else $error("pixels not emitted in ascending port order");

  AST_GROUP_SIZE: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_r.sh == ppm_pkg::PPM_SH_RUN |-> s_r.idx < s_r.slv_cnt)
    else $error("serialiser ran past the group");

  AST_LATENCY: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pix_tick && s_r.dly[DLY_N-1].vld && s_r.dly[DLY_N-1].first
      |-> 4'(s_r.tick_cnt - s_r.dly[DLY_N-1].stamp) == 4'(`PPM_LATENCY - 1))
    else $error("pipeline latency is not nine pixel clocks");

  AST_PAL_WRITE: assert property (@(posedge clk) disable iff (!rst_sync_n)
    host_wr && !host_addr[`PPM_HOST_OVL_BIT]
      |=> pal_mem[$past(host_addr[`PPM_PIX_W-1:0])] == $past(host_data))
    else $error("palette write not stored");

  AST_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_r.push && !fifo_rdy |=> overflow)
    else $error("lost word not flagged");

  // Sideband fields are copied per pixel, so a cut group cannot skew them
  AST_SIDEBAND_ALIGN: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pix_tick && s_r.sh == ppm_pkg::PPM_SH_RUN
      |=> s_r.mux.sync_n == $past(s_r.slv_sync_n) && s_r.mux.blank_n == $past(s_r.slv_blank_n)
          && s_r.mux.ovl == $past(s_r.slv_ovl[s_r.idx]))
    else $error("overlay, sync or blank left the pixel it belongs to");

  // Skipped while the host writes, since the entry may change under the lookup
  AST_PAL_LOOKUP: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pix_tick && s_r.mux.vld && s_r.mux.ovl == 2'h0 && !host_wr
      |=> s_r.look.col == pal_mem[$past(s_r.mux.idx)])
    else $error("palette lookup returned the wrong entry");

  // An empty buffer shows the pushed word at its head one clock later
  AST_OUT_CODES: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_r.push && fifo_rdy && !out_valid
      |=> out_valid && {red, green, blue, sync_n, blank_n}
          == $past({s_r.conv.col, s_r.conv.sync_n, s_r.conv.blank_n}))
    else $error("converter word did not reach the output codes");

  // Only reset clears the flag, so a lost word stays visible until then
  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (!rst_sync_n)
    overflow |=> overflow)
    else $error("overflow flag cleared without reset");

endmodule : ppm_pixel_port_mux

`default_nettype wire

// file: bench/ppm_fb_model.sv
/*
  Frame buffer and clock divider model: a free-running pixel clock and a
  group strobe every four or five pixel clocks while run is high.
  Assumes the consumer samples pixel clock, strobe and ports with a faster clock.
*/
`timescale 1ns/1ns
`default_nettype none

module ppm_fb_model (
  input  wire logic            run,       // Send groups
  input  wire logic            five_req,  // Group size wanted
  input  wire logic [1:0]      ovl_req,   // Overlay select for all ports
  input  wire logic            blank_req, // Blank level of groups
  output logic                 pix_clk,   // Pixel clock, 64 ns
  output logic                 strobe,    // Group load strobe
  output logic [4:0][7:0]      pix,       // Pixel select ports
  output logic [4:0][1:0]      ovl,       // Overlay select ports
  output logic                 sync_n,    // Sync of the group
  output logic                 blank_n,   // Blank of the group
  output logic                 five,      // Group size shown
  output logic [7:0]           grp        // Group number on the ports
);
  logic [2:0] cnt;

  initial begin
    pix_clk = 1'b0;
    strobe = 1'b0;
    pix = '0;
    ovl = '0;
    sync_n = 1'b1;
    blank_n = 1'b1;
    five = 1'b0;
    grp = 8'hff;
    cnt = 3'h0;
    #3;
    forever #32 pix_clk = ~pix_clk;
  end

  // The strobe lags the pixel clock as a divider's delay would
  always @(posedge pix_clk) begin
    #1;
    if (cnt == 3'h0 && run) begin
      grp = grp + 8'h01;
      five = five_req;
      for (int k = 0; k < 5; k++) begin
        pix[k] = {grp[4:0], 3'(k)};
        ovl[k] = ovl_req;
      end
      sync_n = grp[0];
      blank_n = blank_req;
      #12 strobe = 1'b1;
      cnt = 3'h1;
    end else if (cnt != 3'h0) begin
      if (cnt == 3'h2) begin
        strobe = 1'b0;
      end
      cnt = (cnt == (five ? 3'h4 : 3'h3)) ? 3'h0 : cnt + 3'h1;
    end else begin
      // Idle ports change so that no stale group can pass for a fresh one
      pix = ~pix;
      ovl = ~ovl;
    end
  end
endmodule : ppm_fb_model
`default_nettype wire

// file: bench/testbench.sv
/*
  Self-checking bench of the pixel port multiplexer: frame buffer model on
  the pixel side, a stalling receiver on the output side.
  Assumes the model in ppm_fb_model.sv and ppm_map.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  typedef struct packed {
    logic       five;
    logic [1:0] ovl;
    logic       blank;
    logic [3:0] ngrp;
    logic [3:0] lat;
  } ppm_row_t;

  localparam ppm_row_t ROWS [5] = '{'{1'b0, 2'h0, 1'b1, 4'h8, 4'h9},
    '{1'b1, 2'h1, 1'b1, 4'h6, 4'h9}, '{1'b1, 2'h2, 1'b0, 4'h4, 4'h9},
    '{1'b0, 2'h3, 1'b1, 4'h4, 4'h9}, '{1'b1, 2'h0, 1'b1, 4'h8, 4'h9}};

  logic            clk, rstn, host_wr, out_ready, out_valid, sync_n, blank_n;
  logic            buf_ready, overflow, run, five_req, blank_req, pix_clk, strobe;
  logic            sync_n_in, blank_n_in, five, chk_on, lat_arm, lat_run;
  logic [8:0]      host_addr;
  logic [23:0]     host_data;
  logic [7:0]      red, green, blue, grp;
  logic [1:0]      ovl_req, rmode;
  logic [4:0][7:0] pix;
  logic [4:0][1:0] ovl;
  logic [23:0]     pal [256];
  logic [23:0]     ocol [4];
  logic [25:0]     q [$];
  logic [25:0]     ew;
  logic [3:0]      cur_lat;
  int              err_total, n_checks, cyc, lat_cnt;

  ppm_fb_model i_fb (.run(run), .five_req(five_req), .ovl_req(ovl_req),
    .blank_req(blank_req), .pix_clk(pix_clk), .strobe(strobe), .pix(pix), .ovl(ovl),
    .sync_n(sync_n_in), .blank_n(blank_n_in), .five(five), .grp(grp));

  ppm_pixel_port_mux #(.BUF_DEPTH(2)) i_dut (.clk(clk), .rstn(rstn), .pix_clk(pix_clk),
    .pixel_group_load_strobe(strobe), .pix_port(pix), .ovl_port(ovl),
    .sync_n_in(sync_n_in), .blank_n_in(blank_n_in), .group_of_five(five),
    .host_wr(host_wr), .host_addr(host_addr), .host_data(host_data),
    .out_valid(out_valid), .out_ready(out_ready), .red(red), .green(green), .blue(blue),
    .sync_n(sync_n), .blank_n(blank_n), .buf_ready(buf_ready), .overflow(overflow));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic check(input logic [25:0] got, input logic [25:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end

  // Short stalls in mode 2: at most one word can arrive while the receiver waits; mode 0 holds out_ready low throughout
  always @(negedge clk) out_ready <= (rmode == 2'h2) ? ~(cyc[4] & cyc[3]) : rmode[0];

  always @(posedge strobe) begin
    if (lat_arm) begin
      lat_arm = 1'b0;
      lat_run = 1'b1;
      lat_cnt = 0;
    end
    if (chk_on) begin
      for (int k = 0; k < (five ? 5 : 4); k++) begin
        q.push_back({(ovl[k] == 2'h0) ? pal[pix[k]] : ocol[ovl[k]], sync_n_in, blank_n_in});
      end
    end
  end

  always @(posedge pix_clk) if (lat_run) lat_cnt++;

  always @(posedge clk) begin
    if (lat_run && out_valid === 1'b1) begin
      lat_run = 1'b0;
      check(26'(lat_cnt), 26'(cur_lat));
    end
    if (chk_on && out_valid === 1'b1 && out_ready === 1'b1) begin
      ew = q.size() ? q.pop_front() : 26'h3ffffff;
      if (ew[0]) check({red, green, blue, sync_n, blank_n}, ew);
      else check({24'h0, sync_n, blank_n}, {24'h0, ew[1:0]});
    end
  end

  task automatic wr(input logic [8:0] a, input logic [23:0] d);
    host_wr <= 1'b1;
    host_addr <= a;
    host_data <= d;
    @(negedge clk);
  endtask : wr

  task automatic run_row(input ppm_row_t r);
    @(negedge clk);
    five_req = r.five;
    ovl_req = r.ovl;
    blank_req = r.blank;
    cur_lat = r.lat;
    q.delete();
    chk_on = 1'b1;
    lat_arm = 1'b1;
    run = 1'b1;
    repeat (r.ngrp) @(posedge strobe);
    run = 1'b0;
    repeat (400) @(posedge clk);
    check(26'(q.size()), 26'h0);
    check({24'h0, overflow, buf_ready}, 26'h1);
    chk_on = 1'b0;
  endtask : run_row

  initial begin
    {rstn, host_wr, run, five_req, blank_req, chk_on, lat_arm, lat_run} = '0;
    host_addr = '0;
    host_data = '0;
    ovl_req = 2'h0;
    rmode = 2'h1;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 256; i++) begin
      pal[i] = {8'(i), 8'(~i), 8'(i + 8'h31)};
      wr({1'b0, 8'(i)}, pal[i]);
    end
    for (int o = 1; o < 4; o++) begin
      ocol[o] = {8'(o * 8'h55), 8'hc0, 8'(o)};
      wr({1'b1, 8'(o)}, ocol[o]);
    end
    host_wr <= 1'b0;
    rmode = 2'h2;
    for (int i = 0; i < 5; i++) begin
      fork
        run_row(ROWS[i]);
        if (i == 0) begin
          // Entries shown only in the last row, rewritten while pixels flow
          repeat (60) @(negedge clk);
          for (int j = 8'he0; j < 8'hf0; j++) begin
            pal[j] = {8'(j), 8'h3c, 8'(j)};
            wr({1'b0, 8'(j)}, pal[j]);
          end
          host_wr <= 1'b0;
        end
      join
    end
    rmode = 2'h0;
    run = 1'b1;
    repeat (3) @(posedge strobe);
    run = 1'b0;
    repeat (400) @(negedge clk);
    check({23'h0, out_valid, buf_ready, overflow}, 26'h5);
    rmode = 2'h1;
    repeat (10) @(negedge clk);
    check({23'h0, out_valid, buf_ready, overflow}, 26'h3);
    run = 1'b1;
    repeat (2) @(posedge strobe);
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    check({red, green, blue, out_valid, buf_ready}, 26'h1);
    check({25'h0, overflow}, 26'h0);
    rstn = 1'b1;
    run = 1'b0;
    repeat (400) @(negedge clk);
    rmode = 2'h2;
    run_row(ROWS[1]);
    test_done();
  end
endmodule : testbench
`default_nettype wire
